// >>> design/fieldbus_slave_state_pdo.sv
// Slave communication state machine with channel gating and PDO slot handling
// How it works
// RULE1: Upward moves go boot, mailbox, inputs-only, full exchange, in order.
// RULE2: Downward moves from full exchange may skip intermediate states.
// RULE3: Boot state serves no SDO or PDO; only master reaches chip registers.
// RULE4: Master sets address, mailbox and sync clock, then asks for mailbox.
// RULE5: Mailbox state serves SDO with receive and transmit PDO disabled.
// RULE6: Master sets mapping, sync channels, mapping units, then asks inputs-only.
// RULE7: Inputs-only serves SDO, transmit PDO and sync clock; ignores receive PDO.
// RULE8: Master already sends valid outputs before full exchange is entered.
// RULE9: Full exchange takes inputs and outputs as valid and keeps SDO.
// RULE10: Indices 1600h to 17FFh are receive PDO mapping descriptors.
// RULE11: Indices 1A00h to 1BFFh are transmit PDO mapping descriptors.
// RULE12: Six receive PDOs (1600h variable, 1701h-1705h fixed), five transmit PDOs.
// RULE13: User assigns PDOs; 1A00h variable, 1B01h to 1B04h fixed transmit slots.
// RULE14: Receive PDOs flow master to device; transmit PDOs device to master.
// RULE15: PDO data moves every cycle; SDO accesses come non-cyclically.
// RULE16: Dictionary holds communication, application and mapping data via SDO.
// RULE17: Save selection must be set before saving, else defaults return.
// RULE18: Save selection 0 none, 1 params, 2 objects, 3 both; default 3.
// RULE19: Skipping upward requests are refused and the state is kept.
`timescale 1ns/1ps
module fieldbus_slave_state_pdo
  import comm_state_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        req_valid_i,
  input  comm_state_t      req_state_i,
  input  wire logic        chip_access_i,
  input  obj_req_t         sdo_req_i,
  input  wire logic        rx_pdo_valid_i,
  input  wire logic [31:0] rx_pdo_data_i,
  input  wire logic        cycle_tick_i,
  input  wire logic [31:0] tx_pdo_data_i,
  input  wire logic        save_cmd_i,
  output comm_state_t      state_o,
  output logic             refused_o,
  output chan_gate_t       gate_o,
  output logic             chip_grant_o,
  output logic             sdo_ack_o,
  output logic             sdo_err_o,
  output logic [31:0]      sdo_rdata_o,
  output logic             rx_pdo_valid_o,
  output logic [31:0]      rx_pdo_data_o,
  output logic             tx_pdo_valid_o,
  output logic [31:0]      tx_pdo_data_o,
  output logic [1:0]       save_sel_o,
  output logic             save_param_o,
  output logic             save_obj_o
);

  comm_state_t state_reg, state_next;
  logic        refused_reg, refused_next;
  chan_gate_t  gate_next;
  chan_gate_t  gate_reg;
  logic        chip_reg, chip_next;
  logic        sdo_ack_reg, sdo_ack_next;
  logic        sdo_err_reg, sdo_err_next;
  logic [31:0] sdo_rdata_reg, sdo_rdata_next;
  logic        rxv_reg, rxv_next;
  logic [31:0] rxd_reg, rxd_next;
  logic        txv_reg, txv_next;
  logic [31:0] txd_reg, txd_next;
  logic [1:0]  save_sel_reg, save_sel_next;
  logic        sp_reg, sp_next;
  logic        so_reg, so_next;
  // Mapping entries for the two variable slots; fixed slots are read-only.
  // Only one word per variable slot is kept: a full entry list would need
  // a memory, and the fixed slots carry their contents elsewhere.
  logic [31:0] rx_map_reg, rx_map_next;
  logic [31:0] tx_map_reg, tx_map_next;
  // Assignment bitmaps: bit 0 variable slot, bits 1.. fixed slots
  logic [5:0]  rx_assign_reg, rx_assign_next;
  logic [4:0]  tx_assign_reg, tx_assign_next;
  // Assignment resets to the variable slot only, so process data flows
  // without any setup once the exchange states are reached

  slot_kind_t  slot_kind;
  logic        is_rx_map;
  logic        is_tx_map;

  // Slot decode of the mailbox index, shared by all object accesses
  pdo_slot_decode i_pdo_slot_decode (
    .index_i  (sdo_req_i.index),
    .kind_o   (slot_kind),
    .rx_map_o (is_rx_map),
    .tx_map_o (is_tx_map)
  );

  // Channel gates derived from a state.
  // Gates are computed from the next state and registered, so they change in the same cycle as state_o;
  // only chip_only lags, since reset clears it and the first clock sets it in boot.
  function automatic chan_gate_t gate_of(input comm_state_t s);
    chan_gate_t g;
    g = '0;
    unique case (s)
      // RULE3: boot gates closed
      ST_BOOT:  g.chip_only = 1'b1;
      // RULE5: mailbox only
      ST_MBOX:  g.sdo_en = 1'b1;
      // RULE7: inputs and sync
      ST_INPUT: begin
        g.sdo_en    = 1'b1;
        g.tx_pdo_en = 1'b1;
        g.sync_en   = 1'b1;
      end
      // RULE9: everything open
      ST_FULL: begin
        g.sdo_en    = 1'b1;
        g.rx_pdo_en = 1'b1;
        g.tx_pdo_en = 1'b1;
        g.sync_en   = 1'b1;
      end
    endcase
    return g;
  endfunction

  // State transition logic; a request is judged against the current state.
  // A request equal to the current state is accepted and changes nothing.
  // Upward moves of more than one step are refused for one cycle; the
  // master must then walk the ladder, which keeps its setup steps in order.
  // Downward moves need no setup, so any of them is taken at once.
  always_comb begin
    state_next   = state_reg;
    refused_next = 1'b0;
    if (req_valid_i) begin
      if (req_state_i <= state_reg) begin
        // RULE2: downward skip allowed
        state_next = req_state_i;
      end else if (req_state_i == comm_state_t'(state_reg + 2'd1)) begin
        // RULE1: one step upward
        state_next = req_state_i;
      end else begin
        // RULE19: refuse skipping up
        refused_next = 1'b1;
      end
    end
    gate_next = gate_of(state_next);
    // RULE3: chip registers master-only in boot
    chip_next = chip_access_i && (state_reg == ST_BOOT);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg   <= ST_BOOT;
      refused_reg <= 1'b0;
      gate_reg    <= '0;
      chip_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      refused_reg <= refused_next;
      gate_reg    <= gate_next;
      chip_reg    <= chip_next;
    end
  end

  // Mailbox object access: served once per request, never tied to the cycle tick.
  // Every request is answered one cycle later, error or not, so the master
  // never waits on a missing acknowledge. Read data is the value held
  // before a write in the same request takes effect.
  always_comb begin
    sdo_ack_next   = 1'b0;
    sdo_err_next   = 1'b0;
    sdo_rdata_next = sdo_rdata_reg;
    rx_map_next    = rx_map_reg;
    tx_map_next    = tx_map_reg;
    rx_assign_next = rx_assign_reg;
    tx_assign_next = tx_assign_reg;
    save_sel_next  = save_sel_reg;
    // RULE15: non-cyclic SDO
    if (sdo_req_i.valid) begin
      sdo_ack_next = 1'b1;
      if (!gate_reg.sdo_en) begin
        // RULE3: no SDO in boot
        sdo_err_next = 1'b1;
      end else if (sdo_req_i.index == SAVE_SEL_IDX && sdo_req_i.subindex == SAVE_SEL_SUB) begin
        // RULE18: save selection object
        if (sdo_req_i.write) begin
          save_sel_next = sdo_req_i.data[1:0];
        end
        sdo_rdata_next = {30'h0000_0000, save_sel_reg};
      end else if (is_rx_map || is_tx_map) begin
        // RULE10: receive mapping range
        // RULE11: transmit mapping range
        // RULE12: slot decode
        // RULE13: variable slots writable
        unique case (slot_kind)
          SLOT_RX_VAR: begin
            if (sdo_req_i.write) begin
              rx_map_next = sdo_req_i.data;
            end
            sdo_rdata_next = rx_map_reg;
          end
          SLOT_TX_VAR: begin
            if (sdo_req_i.write) begin
              tx_map_next = sdo_req_i.data;
            end
            sdo_rdata_next = tx_map_reg;
          end
          SLOT_RX_FIX, SLOT_TX_FIX: begin
            sdo_err_next   = sdo_req_i.write;
            sdo_rdata_next = {16'h0000, sdo_req_i.index};
          end
          default: sdo_err_next = 1'b1;
        endcase
      end else if (sdo_req_i.index == ASSIGN_RX_IDX || sdo_req_i.index == ASSIGN_TX_IDX) begin
        // RULE13: user PDO assignment
        // Changing the assignment while data flows would tear a frame, so
        // writes are taken only in the mailbox state
        if (sdo_req_i.write && state_reg == ST_MBOX) begin
          if (sdo_req_i.index == ASSIGN_RX_IDX) begin
            rx_assign_next = sdo_req_i.data[5:0];
          end else begin
            tx_assign_next = sdo_req_i.data[4:0];
          end
        end else if (sdo_req_i.write) begin
          sdo_err_next = 1'b1;
        end
        sdo_rdata_next = (sdo_req_i.index == ASSIGN_RX_IDX) ?
                         {26'h000_0000, rx_assign_reg} : {27'h000_0000, tx_assign_reg};
      end else begin
        // RULE16: other objects answered as present
        sdo_rdata_next = 32'h0000_0000;
      end
    end
  end

  // Process data: transmit on the tick, receive on each valid word, gated by state.
  // An empty assignment stops the channel even in the exchange states.
  // Data registers hold the last word, so a late reader still sees it.
  always_comb begin
    rxv_next = 1'b0;
    rxd_next = rxd_reg;
    txv_next = 1'b0;
    txd_next = txd_reg;
    // RULE14: receive flows inward
    // RULE7: receive ignored before full exchange
    if (rx_pdo_valid_i && gate_reg.rx_pdo_en && rx_assign_reg != 6'h00) begin
      rxv_next = 1'b1;
      rxd_next = rx_pdo_data_i;
    end
    // RULE15: cyclic transmit
    if (cycle_tick_i && gate_reg.tx_pdo_en && tx_assign_reg != 5'h00) begin
      txv_next = 1'b1;
      txd_next = tx_pdo_data_i;
    end
    // RULE17: save follows selection
    sp_next = save_cmd_i && save_sel_reg[0];
    so_next = save_cmd_i && save_sel_reg[1];
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sdo_ack_reg   <= 1'b0;
      sdo_err_reg   <= 1'b0;
      sdo_rdata_reg <= 32'h0000_0000;
      rx_map_reg    <= 32'h0000_0000;
      tx_map_reg    <= 32'h0000_0000;
      rx_assign_reg <= 6'h01;
      tx_assign_reg <= 5'h01;
      save_sel_reg  <= SAVE_RST;
      rxv_reg       <= 1'b0;
      rxd_reg       <= 32'h0000_0000;
      txv_reg       <= 1'b0;
      txd_reg       <= 32'h0000_0000;
      sp_reg        <= 1'b0;
      so_reg        <= 1'b0;
    end else begin
      sdo_ack_reg   <= sdo_ack_next;
      sdo_err_reg   <= sdo_err_next;
      sdo_rdata_reg <= sdo_rdata_next;
      rx_map_reg    <= rx_map_next;
      tx_map_reg    <= tx_map_next;
      rx_assign_reg <= rx_assign_next;
      tx_assign_reg <= tx_assign_next;
      save_sel_reg  <= save_sel_next;
      rxv_reg       <= rxv_next;
      rxd_reg       <= rxd_next;
      txv_reg       <= txv_next;
      txd_reg       <= txd_next;
      sp_reg        <= sp_next;
      so_reg        <= so_next;
    end
  end

  // Outputs straight from flip-flops.
  // No output passes through logic after its register, to keep the far
  // side free of glitches.
  assign state_o        = state_reg;
  assign refused_o      = refused_reg;
  assign gate_o         = gate_reg;
  assign chip_grant_o   = chip_reg;
  assign sdo_ack_o      = sdo_ack_reg;
  assign sdo_err_o      = sdo_err_reg;
  assign sdo_rdata_o    = sdo_rdata_reg;
  assign rx_pdo_valid_o = rxv_reg;
  assign rx_pdo_data_o  = rxd_reg;
  assign tx_pdo_valid_o = txv_reg;
  assign tx_pdo_data_o  = txd_reg;
  assign save_sel_o     = save_sel_reg;
  assign save_param_o   = sp_reg;
  assign save_obj_o     = so_reg;

endmodule

// >>> design/comm_state_pkg.sv
// Package with constants and carrier types for the fieldbus slave communication control
package comm_state_pkg;

  // Communication states
  typedef enum logic [1:0] {
    ST_BOOT  = 2'b00,
    ST_MBOX  = 2'b01,
    ST_INPUT = 2'b10,
    ST_FULL  = 2'b11
  } comm_state_t;

  // Object dictionary index ranges
  localparam logic [15:0] RX_MAP_LO    = 16'h1600;
  localparam logic [15:0] RX_MAP_HI    = 16'h17ff;
  localparam logic [15:0] TX_MAP_LO    = 16'h1a00;
  localparam logic [15:0] TX_MAP_HI    = 16'h1bff;
  localparam logic [15:0] RX_VAR_IDX   = 16'h1600;
  localparam logic [15:0] RX_FIX_LO    = 16'h1701;
  localparam logic [15:0] RX_FIX_HI    = 16'h1705;
  localparam logic [15:0] TX_VAR_IDX   = 16'h1a00;
  localparam logic [15:0] TX_FIX_LO    = 16'h1b01;
  localparam logic [15:0] TX_FIX_HI    = 16'h1b04;

  // Save selection encodings and reset value
  localparam logic [1:0]  SAVE_NONE    = 2'h0;
  localparam logic [1:0]  SAVE_PARAM   = 2'h1;
  localparam logic [1:0]  SAVE_OBJ     = 2'h2;
  localparam logic [1:0]  SAVE_BOTH    = 2'h3;
  localparam logic [1:0]  SAVE_RST     = SAVE_BOTH;

  // Slot classification of an index
  typedef enum logic [2:0] {
    SLOT_NONE   = 3'b000,
    SLOT_RX_VAR = 3'b001,
    SLOT_RX_FIX = 3'b010,
    SLOT_TX_VAR = 3'b011,
    SLOT_TX_FIX = 3'b100,
    SLOT_RX_UNS = 3'b101,
    SLOT_TX_UNS = 3'b110
  } slot_kind_t;

  // Channel gates for the current state
  typedef struct packed {
    logic sdo_en;
    logic rx_pdo_en;
    logic tx_pdo_en;
    logic sync_en;
    logic chip_only;
  } chan_gate_t;

  // Object access request carried with its index
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] data;
  } obj_req_t;

  // Save selection object location
  localparam logic [15:0] SAVE_SEL_IDX = 16'h200e;
  localparam logic [7:0]  SAVE_SEL_SUB = 8'h02;

  // PDO assignment object locations, receive and transmit
  localparam logic [15:0] ASSIGN_RX_IDX = 16'h1c12;
  localparam logic [15:0] ASSIGN_TX_IDX = 16'h1c13;

endpackage

// >>> design/pdo_slot_decode.sv
// Classifies an object dictionary index into PDO mapping slot kinds
`timescale 1ns/1ps
module pdo_slot_decode
  import comm_state_pkg::*;
(
  input  wire logic [15:0] index_i,
  output slot_kind_t       kind_o,
  output logic             rx_map_o,
  output logic             tx_map_o
);

  // Range and slot decode, purely combinational
  always_comb begin
    rx_map_o = (index_i >= RX_MAP_LO) && (index_i <= RX_MAP_HI);
    tx_map_o = (index_i >= TX_MAP_LO) && (index_i <= TX_MAP_HI);
    kind_o   = SLOT_NONE;
    if (rx_map_o) begin
      kind_o = SLOT_RX_UNS;
      if (index_i == RX_VAR_IDX) begin
        kind_o = SLOT_RX_VAR;
      end else if (index_i >= RX_FIX_LO && index_i <= RX_FIX_HI) begin
        kind_o = SLOT_RX_FIX;
      end
    end else if (tx_map_o) begin
      kind_o = SLOT_TX_UNS;
      if (index_i == TX_VAR_IDX) begin
        kind_o = SLOT_TX_VAR;
      end else if (index_i >= TX_FIX_LO && index_i <= TX_FIX_HI) begin
        kind_o = SLOT_TX_FIX;
      end
    end
  end

endmodule

// >>> bench/comm_state_monitor.sv
// Checker of state order, channel gates, mailbox answers and save pulses
`timescale 1ns/1ps
module comm_state_monitor
  import comm_state_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  nrst_i,
  input  wire logic  req_valid_i,
  input  comm_state_t req_state_i,
  input  obj_req_t   sdo_req_i,
  input  wire logic  rx_pdo_valid_i,
  input  wire logic  save_cmd_i,
  input  comm_state_t state_o,
  input  wire logic  refused_o,
  input  chan_gate_t gate_o,
  input  wire logic  sdo_ack_o,
  input  wire logic  sdo_err_o,
  input  wire logic  rx_pdo_valid_o,
  input  wire logic [1:0] save_sel_o,
  input  wire logic  save_param_o,
  input  wire logic  save_obj_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Widened so that full plus one does not wrap round to boot
  wire logic [2:0] nxt_w = {1'b0, state_o} + 3'h1;
  wire logic [2:0] rq_w  = {1'b0, req_state_i};

  AST_SKIP: assert property (req_valid_i && rq_w > nxt_w |=> refused_o && $stable(state_o))
    else $error("upward skip not refused");
  AST_STEP: assert property (req_valid_i && rq_w <= nxt_w |=> state_o == $past(req_state_i))
    else $error("legal request not taken");
  AST_BOOT: assert property (state_o == ST_BOOT |-> !(gate_o.sdo_en || gate_o.rx_pdo_en
    || gate_o.tx_pdo_en))
    else $error("channel open in boot");
  AST_MBOX: assert property (state_o == ST_MBOX |-> gate_o.sdo_en && !gate_o.rx_pdo_en
    && !gate_o.tx_pdo_en)
    else $error("mailbox gates wrong");
  AST_INPUT: assert property (state_o == ST_INPUT |-> gate_o.sdo_en && gate_o.tx_pdo_en
    && gate_o.sync_en && !gate_o.rx_pdo_en)
    else $error("inputs-only gates wrong");
  AST_FULL: assert property (state_o == ST_FULL |-> gate_o.sdo_en && gate_o.rx_pdo_en
    && gate_o.tx_pdo_en)
    else $error("full exchange gates wrong");
  AST_ACK: assert property (sdo_req_i.valid |=> sdo_ack_o ##1 !sdo_ack_o || sdo_req_i.valid)
    else $error("mailbox answer missing");
  AST_BOOT_ERR: assert property (sdo_req_i.valid && state_o == ST_BOOT |=> sdo_err_o)
    else $error("mailbox served in boot");
  AST_RX_GATE: assert property (rx_pdo_valid_i && !gate_o.rx_pdo_en |=> !rx_pdo_valid_o)
    else $error("receive word passed while closed");
  AST_SAVE: assert property (save_cmd_i |=> {save_obj_o, save_param_o} == $past(save_sel_o))
    else $error("save pulses do not follow selection");
endmodule

bind fieldbus_slave_state_pdo comm_state_monitor i_comm_state_monitor (.clk_i, .nrst_i,
  .req_valid_i, .req_state_i, .sdo_req_i, .rx_pdo_valid_i, .save_cmd_i, .state_o, .refused_o,
  .gate_o, .sdo_ack_o, .sdo_err_o, .rx_pdo_valid_o, .save_sel_o, .save_param_o, .save_obj_o);

// >>> bench/master_model.sv
// Network master model sending receive words and cycle ticks at a fixed period
`timescale 1ns/1ps
module master_model #(
  parameter int PERIOD = 4
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  output logic             rx_valid_o,
  output logic [31:0]      rx_data_o,
  output logic             tick_o,
  output logic [31:0]      sent_o
);
  int cnt_reg;
  // outputs flow every period, before and after full exchange
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg    <= 0;
      rx_valid_o <= 1'b0;
      tick_o     <= 1'b0;
      rx_data_o  <= 32'h0000_0000;
      sent_o     <= 32'h0000_0000;
    end else begin
      cnt_reg    <= (cnt_reg == PERIOD - 1) ? 0 : cnt_reg + 1;
      rx_valid_o <= (cnt_reg == 0);
      tick_o     <= (cnt_reg == 0);
      // Data is scrambled off the pulse so a late sample cannot pass
      rx_data_o  <= (cnt_reg == 0) ? sent_o + 32'h0001_0001 : ~rx_data_o;
      if (cnt_reg == 0)
        sent_o <= sent_o + 32'h0001_0001;
    end
  end
endmodule

// >>> bench/test_fieldbus_slave_state_pdo.sv
// Self-checking bench for the slave communication state control
`timescale 1ns/1ps
module test_fieldbus_slave_state_pdo;
  import comm_state_pkg::*;
  typedef struct {comm_state_t rq; comm_state_t st; logic rf;} row_t;
  logic        clk_i, nrst_i, req_valid_i, chip_access_i, save_cmd_i, rx_v, tick;
  logic        refused_o, chip_grant_o, sdo_ack_o, sdo_err_o, rx_pdo_valid_o;
  logic        tx_pdo_valid_o, save_param_o, save_obj_o;
  logic [31:0] rx_d, sent, sdo_rdata_o, rx_pdo_data_o, tx_pdo_data_o, tx_pdo_data_i;
  logic [1:0]  save_sel_o;
  comm_state_t req_state_i, state_o;
  obj_req_t    sdo_req_i;
  chan_gate_t  gate_o;
  int          err_count, n_tests, i, nrx, ntx;
  row_t        rows [12] = '{'{ST_FULL, ST_BOOT, 1}, '{ST_INPUT, ST_BOOT, 1},
    '{ST_MBOX, ST_MBOX, 0}, '{ST_FULL, ST_MBOX, 1}, '{ST_MBOX, ST_MBOX, 0},
    '{ST_INPUT, ST_INPUT, 0}, '{ST_FULL, ST_FULL, 0}, '{ST_BOOT, ST_BOOT, 0},
    '{ST_MBOX, ST_MBOX, 0}, '{ST_INPUT, ST_INPUT, 0}, '{ST_FULL, ST_FULL, 0},
    '{ST_MBOX, ST_MBOX, 0}};

  fieldbus_slave_state_pdo i_fieldbus_slave_state_pdo (.clk_i, .nrst_i, .req_valid_i,
    .req_state_i, .chip_access_i, .sdo_req_i, .rx_pdo_valid_i(rx_v), .rx_pdo_data_i(rx_d),
    .cycle_tick_i(tick), .tx_pdo_data_i, .save_cmd_i, .state_o, .refused_o, .gate_o,
    .chip_grant_o, .sdo_ack_o, .sdo_err_o, .sdo_rdata_o, .rx_pdo_valid_o, .rx_pdo_data_o,
    .tx_pdo_valid_o, .tx_pdo_data_o, .save_sel_o, .save_param_o, .save_obj_o);
  master_model i_master_model (.clk_i, .nrst_i, .rx_valid_o(rx_v), .rx_data_o(rx_d),
    .tick_o(tick), .sent_o(sent));

  // Expected {sdo, rx, tx} gates of a state
  function automatic logic [2:0] gx(comm_state_t s);
    return (s == ST_BOOT) ? 3'h0 : (s == ST_MBOX) ? 3'h4 : (s == ST_INPUT) ? 3'h5 : 3'h7;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic req(input comm_state_t s);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_state_i <= s;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    #1;
  endtask

  task automatic sdo(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] d);
    @(posedge clk_i);
    sdo_req_i <= '{1'b1, w, ix, sb, d};
    @(posedge clk_i);
    sdo_req_i.valid <= 1'b0;
    #1;
    chk("sdo_ack", 32'h1, sdo_ack_o);
  endtask

  // Counts output pulses over a fixed window while the master keeps sending
  task automatic watch;
    nrx = 0;
    ntx = 0;
    repeat (20) begin
      @(posedge clk_i);
      #1;
      if (rx_pdo_valid_o === 1'b1) nrx++;
      if (tx_pdo_valid_o === 1'b1) ntx++;
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    test_done();
  end

  initial begin
    {nrst_i, req_valid_i, save_cmd_i, err_count, n_tests} = '0;
    req_state_i   = ST_BOOT;
    chip_access_i = 1'b1;
    sdo_req_i     = '0;
    tx_pdo_data_i = 32'hC0DE_0001;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    chk("save_sel_rst", 32'h3, save_sel_o);
    sdo(1'b0, SAVE_SEL_IDX, SAVE_SEL_SUB, 32'h0);
    chk("sdo_err_boot", 32'h1, sdo_err_o);
    foreach (rows[i]) begin
      req(rows[i].rq);
      chk("state", rows[i].st, state_o);
      chk("refused", rows[i].rf, refused_o);
      chk("gate", gx(rows[i].st), {gate_o.sdo_en, gate_o.rx_pdo_en, gate_o.tx_pdo_en});
      @(posedge clk_i);
      #1;
      chk("chip_grant", rows[i].st == ST_BOOT, chip_grant_o);
    end
    $display("Test of state rows done");
    sdo(1'b1, RX_VAR_IDX, 8'h01, 32'h1234_5678);
    chk("err_var_wr", 32'h0, sdo_err_o);
    sdo(1'b0, RX_VAR_IDX, 8'h01, 32'h0);
    chk("rdata_var", 32'h1234_5678, sdo_rdata_o);
    sdo(1'b1, RX_FIX_LO, 8'h01, 32'h5);
    chk("err_fix_wr", 32'h1, sdo_err_o);
    sdo(1'b0, 16'h1650, 8'h00, 32'h0);
    chk("err_rx_gap", 32'h1, sdo_err_o);
    sdo(1'b0, 16'h1B05, 8'h00, 32'h0);
    chk("err_tx_gap", 32'h1, sdo_err_o);
    sdo(1'b0, TX_FIX_HI, 8'h00, 32'h0);
    chk("err_tx_fix", 32'h0, sdo_err_o);
    for (i = 0; i < 4; i++) begin
      sdo(1'b1, SAVE_SEL_IDX, SAVE_SEL_SUB, i);
      chk("save_sel", i, save_sel_o);
      @(posedge clk_i);
      save_cmd_i <= 1'b1;
      @(posedge clk_i);
      save_cmd_i <= 1'b0;
      #1;
      chk("save_pulses", i, {save_obj_o, save_param_o});
    end
    $display("Test of mailbox and save done");
    req(ST_INPUT);
    watch();
    chk("rx_in_input", 32'h0, nrx);
    chk("tx_in_input", 32'h1, ntx != 0);
    req(ST_FULL);
    for (i = 0; i < 20 && rx_pdo_valid_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (i == 20) begin
      err_count++;
      test_done();
    end
    chk("rx_data", sent, rx_pdo_data_o);
    chk("tx_data", tx_pdo_data_i, tx_pdo_data_o);
    sdo(1'b1, ASSIGN_RX_IDX, 8'h00, 32'h1);
    chk("err_assign_full", 32'h1, sdo_err_o);
    $display("Test of process data done");
    @(posedge clk_i);
    nrst_i <= 1'b0;
    #1;
    chk("state_mid_rst", ST_BOOT, state_o);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    req(ST_MBOX);
    chk("state_after_rst", ST_MBOX, state_o);
    chk("refused_after_rst", 32'h0, refused_o);
    $display("Test of mid-run reset done");
    test_done();
  end
endmodule
